// >>> pkg/ldf_pkg.sv
/*
 Constants and state encodings shared by the dimming and fault controller.
 Assumes a 100 MHz core clock and two dimming channels.
*/
`default_nettype none
package ldf_pkg;
   localparam int unsigned CLK_MHZ          = 100;
   localparam int unsigned NUM_CH           = 2;
   // Times in their own units
   localparam int unsigned MIN_PULSE_US     = 1;
   localparam int unsigned SLEEP_IDLE_MS    = 4;
   localparam int unsigned RETEST_HOLD_MS   = 128;
   localparam int unsigned SOFT_START_US    = 200;
   // Derived cycle counts
   localparam int unsigned MIN_PULSE_CYC    = MIN_PULSE_US * CLK_MHZ;
   localparam int unsigned SLEEP_IDLE_CYC   = SLEEP_IDLE_MS * 1000 * CLK_MHZ;
   localparam int unsigned RETEST_HOLD_CYC  = RETEST_HOLD_MS * 1000 * CLK_MHZ;
   localparam int unsigned SOFT_START_CYC   = SOFT_START_US * CLK_MHZ;
   localparam int unsigned CNT_W            = 24;
   localparam int unsigned RAMP_W           = 8;
   localparam logic [7:0]  RAMP_FULL        = 8'hFF;
   localparam logic [7:0]  RAMP_ZERO        = 8'h00;

   typedef enum logic [1:0]
   {
      LDF_CH_RUN   = 2'b00,
      LDF_CH_HOLD  = 2'b01,
      LDF_CH_FAULT = 2'b10
   } ldf_ch_state_e;
endpackage : ldf_pkg
`default_nettype wire

// >>> logic/ldf_soft_start.sv
/*
 Soft-start ramp: level rises from zero to full over a fixed time.
 Assumes restart pulses from the controller; one clock domain.
*/
`default_nettype none
module ldf_soft_start
   import ldf_pkg::*;
#(
   parameter int unsigned RAMP_CYC = SOFT_START_CYC
)
(
   // Clock and reset
   input  wire logic              i_clock,
   input  wire logic              i_rst_n,
   input  wire logic              i_enable,
   // Control
   input  wire logic              i_restart,
   input  wire logic              i_run,
   // Level
   output logic [RAMP_W-1:0]      o_level
);
   localparam int unsigned STEP_CYC = (RAMP_CYC / 255 > 0) ? RAMP_CYC / 255 : 1;
   logic [15:0] step_cnt_ff;

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         step_cnt_ff <= 16'h0000;
         o_level     <= RAMP_ZERO;
      end
      else if (i_enable)
      begin
         if (i_restart || !i_run)
         begin
            step_cnt_ff <= 16'h0000;
            o_level     <= RAMP_ZERO;
         end
         else if (o_level != RAMP_FULL)
         begin
            if (step_cnt_ff == 16'(STEP_CYC - 1))
            begin
               step_cnt_ff <= 16'h0000;
               o_level     <= o_level + 8'h01;
            end
            else
               step_cnt_ff <= step_cnt_ff + 16'h0001;
         end
      end
   end
endmodule // ldf_soft_start
`default_nettype wire

// >>> logic/ldf_channel.sv
/*
 One dimming channel: sink gating, open/short hold and retest.
 Assumes the dimming input and analog fault flags are synchronous.
*/
`default_nettype none
module ldf_channel
   import ldf_pkg::*;
#(
   parameter int unsigned HOLD_CYC = RETEST_HOLD_CYC
)
(
   // Clock and reset
   input  wire logic              i_clock,
   input  wire logic              i_rst_n,
   input  wire logic              i_enable,
   // Inputs
   input  wire logic              i_dimming_input,
   input  wire logic              i_allow,
   input  wire logic              i_led_open,
   input  wire logic              i_led_short,
   input  wire logic              i_low_headroom,
   // Outputs
   output logic                   o_sink_on,
   output logic                   o_fault_low,
   output logic                   o_headroom_bad,
   output logic                   o_in_fault
);
   ldf_ch_state_e  state_ff;
   logic [CNT_W-1:0] hold_cnt_ff;
   logic           abnormal;

   assign abnormal = i_led_open | i_led_short;

   // Per-channel state only, so a fault here leaves the others alone
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         state_ff    <= LDF_CH_RUN;
         hold_cnt_ff <= '0;
      end
      else if (i_enable)
      begin
         case (state_ff)
            LDF_CH_RUN:
            begin
               hold_cnt_ff <= '0;
               if (o_sink_on && abnormal)
                  state_ff <= LDF_CH_HOLD;
            end
            LDF_CH_HOLD:
            begin
               if (hold_cnt_ff == CNT_W'(HOLD_CYC - 1))
               begin
                  hold_cnt_ff <= '0;
                  // Retest at end of hold window
                  state_ff    <= abnormal ? LDF_CH_FAULT : LDF_CH_RUN;
               end
               else
                  hold_cnt_ff <= hold_cnt_ff + CNT_W'(1);
            end
            LDF_CH_FAULT:
            begin
               // Fault persists until the condition clears
               if (!abnormal)
                  state_ff <= LDF_CH_RUN;
            end
            default:
               state_ff <= LDF_CH_RUN;
         endcase
      end
   end

   // Sink follows the dimming level with no filtering, so 1 us pulses pass
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         o_sink_on      <= 1'b0;
         o_fault_low    <= 1'b0;
         o_headroom_bad <= 1'b0;
         o_in_fault     <= 1'b0;
      end
      else if (i_enable)
      begin
         o_sink_on      <= i_dimming_input && i_allow && (state_ff == LDF_CH_RUN);
         o_fault_low    <= (state_ff == LDF_CH_HOLD);
         o_headroom_bad <= i_dimming_input && i_low_headroom;
         o_in_fault     <= (state_ff != LDF_CH_RUN);
      end
   end
endmodule // ldf_channel
`default_nettype wire

// >>> logic/ldf_controller.sv
/*
 Dimming, low-power and protection controller for a linear LED sink driver.
 Assumes comparator flags (supply, temperature, open/short, headroom)
 arrive synchronous to i_clock; the fault pin wire is resolved outside.
*/
`default_nettype none
module ldf_controller
   import ldf_pkg::*;
#(
   parameter int unsigned SLEEP_CYC = SLEEP_IDLE_CYC,
   parameter int unsigned HOLD_CYC  = RETEST_HOLD_CYC,
   parameter int unsigned RAMP_CYC  = SOFT_START_CYC
)
(
   // Clock, reset, enable
   input  wire logic              i_clock,
   input  wire logic              i_rst_n,
   input  wire logic              i_enable,
   // Host dimming inputs
   input  wire logic [NUM_CH-1:0] i_dimming_input,
   // Analog comparator flags
   input  wire logic              i_supply_above_6v,
   input  wire logic              i_supply_above_5v7,
   input  wire logic              i_temp_at_160c,
   input  wire logic              i_temp_below_130c,
   input  wire logic [NUM_CH-1:0] i_led_open,
   input  wire logic [NUM_CH-1:0] i_led_short,
   input  wire logic [NUM_CH-1:0] i_low_headroom,
   // Shared fault line level
   input  wire logic              i_fault_report_n,
   // Channel sinks
   output logic [NUM_CH-1:0]      o_channel_sink_on,
   output logic [RAMP_W-1:0]      o_sink_level,
   // Headroom current enable
   output logic                   o_headroom_good_output,
   // Open-drain fault pin
   output logic                   o_fault_report_n_out,
   output logic                   o_fault_report_n_oe,
   // Status
   output logic                   o_low_power,
   output logic                   o_undervoltage_lockout,
   output logic                   o_thermal_shutdown,
   output logic [NUM_CH-1:0]      o_channel_fault,
   output logic                   o_fault_line_low
);
   logic [CNT_W-1:0]  idle_cnt_ff;
   logic              undervoltage_lockout_ff;
   logic              otp_ff;
   logic              restart_ff;
   logic              any_dim;
   logic              driver_allow;
   logic [NUM_CH-1:0] ch_sink;
   logic [NUM_CH-1:0] ch_hold;
   logic [NUM_CH-1:0] ch_bad;
   logic [NUM_CH-1:0] ch_fault;
   logic [RAMP_W-1:0] ramp_level;
   logic              any_fault;

   assign any_dim      = |i_dimming_input;
   assign driver_allow = !undervoltage_lockout_ff && !otp_ff && !o_low_power;

   // Inactivity timer and low-power entry/exit
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         idle_cnt_ff <= '0;
         o_low_power <= 1'b0;
      end
      else if (i_enable)
      begin
         if (any_dim)
         begin
            idle_cnt_ff <= '0;
            o_low_power <= 1'b0;
         end
         else if (idle_cnt_ff == CNT_W'(SLEEP_CYC - 1))
            o_low_power <= 1'b1;
         else
            idle_cnt_ff <= idle_cnt_ff + CNT_W'(1);
      end
   end

   // Supply lockout with hysteresis between the two thresholds
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
         undervoltage_lockout_ff <= 1'b1;
      else if (i_enable)
      begin
         if (!i_supply_above_5v7)
            undervoltage_lockout_ff <= 1'b1;
         else if (i_supply_above_6v)
            undervoltage_lockout_ff <= 1'b0;
      end
   end

   // Thermal shutdown with 160/130 C hysteresis
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
         otp_ff <= 1'b0;
      else if (i_enable)
      begin
         if (i_temp_at_160c)
            otp_ff <= 1'b1;
         else if (i_temp_below_130c)
            otp_ff <= 1'b0;
      end
   end

   // Ramp restarts whenever the driver is released or lit from dark
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
         restart_ff <= 1'b0;
      else if (i_enable)
         restart_ff <= !driver_allow || !any_dim;
   end

   ldf_soft_start #(
      .RAMP_CYC (RAMP_CYC)
   ) u_ramp (
      .i_clock   (i_clock),
      .i_rst_n   (i_rst_n),
      .i_enable  (i_enable),
      .i_restart (restart_ff),
      .i_run     (driver_allow),
      .o_level   (ramp_level)
   );

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g = g + 1)
      begin : g_ch
         ldf_channel #(
            .HOLD_CYC (HOLD_CYC)
         ) u_ch (
            .i_clock         (i_clock),
            .i_rst_n         (i_rst_n),
            .i_enable        (i_enable),
            .i_dimming_input (i_dimming_input[g]),
            .i_allow         (driver_allow),
            .i_led_open      (i_led_open[g]),
            .i_led_short     (i_led_short[g]),
            .i_low_headroom  (i_low_headroom[g]),
            .o_sink_on       (ch_sink[g]),
            .o_fault_low     (ch_hold[g]),
            .o_headroom_bad  (ch_bad[g]),
            .o_in_fault      (ch_fault[g])
         );
      end
   endgenerate

   // Fault is any of thermal, open/short hold, lockout
   assign any_fault = otp_ff | undervoltage_lockout_ff | (|ch_hold);

   // Outputs registered; thermal and lockout also gate sinks here
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         o_channel_sink_on      <= '0;
         o_sink_level           <= RAMP_ZERO;
         o_headroom_good_output <= 1'b0;
         o_fault_report_n_out   <= 1'b0;
         o_fault_report_n_oe    <= 1'b0;
         o_undervoltage_lockout <= 1'b1;
         o_thermal_shutdown     <= 1'b0;
         o_channel_fault        <= '0;
         o_fault_line_low       <= 1'b0;
      end
      else if (i_enable)
      begin
         o_channel_sink_on      <= ch_sink & {NUM_CH{driver_allow}};
         o_sink_level           <= ramp_level;
         // Only enabled channels count; none lit means no claim
         o_headroom_good_output <= driver_allow && any_dim && !(|ch_bad);
         // Drain only ever pulls low; pull-up lives on the board
         o_fault_report_n_out   <= 1'b0;
         o_fault_report_n_oe    <= any_fault;
         o_undervoltage_lockout <= undervoltage_lockout_ff;
         o_thermal_shutdown     <= otp_ff;
         o_channel_fault        <= ch_fault;
         // Shared line may be pulled by another device on the bus
         o_fault_line_low       <= !i_fault_report_n;
      end
   end
endmodule // ldf_controller
`default_nettype wire

// >>> testbench/ldf_controller_monitor.sv
/* Checker for ldf_controller, watching its ports only.
   Assumes dimming and fault flags hold while i_enable is low; bound from the bench top. */
`default_nettype none
module ldf_controller_monitor
   import ldf_pkg::*;
#(
   parameter int unsigned SLEEP_CYC = 40
)
(
   // Clock and reset
   input wire logic              i_clock,
   input wire logic              i_rst_n,
   // Inputs
   input wire logic [NUM_CH-1:0] i_dimming_input,
   input wire logic [NUM_CH-1:0] i_led_open,
   input wire logic [NUM_CH-1:0] i_led_short,
   // Outputs
   input wire logic [NUM_CH-1:0] o_channel_sink_on,
   input wire logic [RAMP_W-1:0] o_sink_level,
   input wire logic              o_fault_report_n_out,
   input wire logic              o_fault_report_n_oe,
   input wire logic              o_low_power,
   input wire logic              o_undervoltage_lockout,
   input wire logic              o_thermal_shutdown,
   input wire logic [NUM_CH-1:0] o_channel_fault
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] idle_ff;
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);
   // Cycles with every dimming input low
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n || i_dimming_input != '0)
         idle_ff <= 32'h0;
      else
         idle_ff <= idle_ff + 32'h1;
   end
   sequence s_protect;
      (o_thermal_shutdown || o_undervoltage_lockout) [*3];
   endsequence
   a_out_low: assert property (o_fault_report_n_out == 1'b0)
      else $error("fault pin drives high");
   a_protect_line: assert property (s_protect |-> o_fault_report_n_oe)
      else $error("protection without fault line");
   a_protect_sinks: assert property (s_protect |-> o_channel_sink_on == '0)
      else $error("sink on during protection");
   a_sink_dim: assert property ((o_channel_sink_on & ~$past(i_dimming_input, 2)) == '0)
      else $error("sink on with dimming low");
   a_lp_early: assert property ($rose(o_low_power) |-> idle_ff == SLEEP_CYC)
      else $error("low power too early");
   a_lp_due: assert property (idle_ff >= SLEEP_CYC + 3 |-> o_low_power)
      else $error("low power missing");
   a_lp_exit: assert property (o_low_power && i_dimming_input != '0 |-> ##[1:2] !o_low_power)
      else $error("low power kept");
   a_open_line: assert property ((((i_led_open | i_led_short) & o_channel_sink_on) != '0)
      |-> ##[1:4] o_fault_report_n_oe)
      else $error("open or short not reported");
   a_hold_line: assert property ($rose(|o_channel_fault) |-> ##[0:2] o_fault_report_n_oe [*8])
      else $error("hold pulse too short");
   a_ramp_zero: assert property ($fell(o_thermal_shutdown) |-> ##2 o_sink_level < 8'h04)
      else $error("no soft start after shutdown");
endmodule // ldf_controller_monitor
`default_nettype wire

// >>> testbench/ldf_host_model.sv
/* Host model: dimming patterns and the pulled-up fault wire.
   Assumes the bench sets the pattern between edges. */
`default_nettype none
module ldf_host_model
   import ldf_pkg::*;
(
   // Clock and reset
   input  wire logic              i_clock,
   input  wire logic              i_rst_n,
   // Pattern
   input  wire logic [NUM_CH-1:0] i_level,
   input  wire logic [NUM_CH-1:0] i_pwm_en,
   input  wire logic [15:0]       i_high_cyc,
   input  wire logic [15:0]       i_period,
   // Wire parties
   input  wire logic              i_dev_oe,
   input  wire logic              i_dev_out,
   input  wire logic              i_ext_oe,
   // Results
   output logic [NUM_CH-1:0]      o_dimming_input,
   output logic                   o_fault_report_n,
   output logic                   o_irq_seen
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] phase_ff;
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n || phase_ff >= i_period - 16'h1)
         phase_ff <= 16'h0;
      else
         phase_ff <= phase_ff + 16'h1;
   end
   assign o_dimming_input = (i_pwm_en & {NUM_CH{phase_ff < i_high_cyc}}) | (~i_pwm_en & i_level);
   // Pull-up: any party pulling wins
   assign o_fault_report_n = !i_ext_oe && (i_dev_oe ? i_dev_out : 1'b1);
   assign o_irq_seen = !o_fault_report_n;
endmodule // ldf_host_model
`default_nettype wire

// >>> testbench/ldf_controller_tb_top.sv
/* Self-checking bench for ldf_controller with short timers.
   Assumes the host model and checker files compile first. */
`default_nettype none
module ldf_controller_tb_top
   import ldf_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned SLP = 40;
   localparam int unsigned HLD = 64;
   logic              clock = 0;
   logic              rst_n = 0;
   logic              sup6 = 0;
   logic              sup57 = 0;
   logic              t160 = 0;
   logic              t130 = 1;
   logic              ext_oe = 0;
   logic              en = 1;
   logic [NUM_CH-1:0] opn = '0;
   logic [NUM_CH-1:0] sht = '0;
   logic [NUM_CH-1:0] lowh = '0;
   logic [NUM_CH-1:0] lvl = 2'h3;
   logic [NUM_CH-1:0] pwm = '0;
   logic [NUM_CH-1:0] dim, sink, chf;
   logic [7:0]        slev;
   logic              fn, irq, hg, fo, oe, lp, uv, otp, fll;
   int                n_mismatch = 0;
   int                n_compared = 0;
   always #5 clock = ~clock;
   ldf_host_model host_u (.i_clock(clock), .i_rst_n(rst_n), .i_level(lvl), .i_pwm_en(pwm),
      .i_high_cyc(16'h0064), .i_period(16'h03E8), .i_dev_oe(oe), .i_dev_out(fo), .i_ext_oe(ext_oe),
      .o_dimming_input(dim), .o_fault_report_n(fn), .o_irq_seen(irq));
   ldf_controller #(.SLEEP_CYC(SLP), .HOLD_CYC(HLD), .RAMP_CYC(510)) dut_u (.i_clock(clock),
      .i_rst_n(rst_n), .i_enable(en), .i_dimming_input(dim), .i_supply_above_6v(sup6),
      .i_supply_above_5v7(sup57), .i_temp_at_160c(t160), .i_temp_below_130c(t130),
      .i_led_open(opn), .i_led_short(sht), .i_low_headroom(lowh), .i_fault_report_n(fn),
      .o_channel_sink_on(sink), .o_sink_level(slev), .o_headroom_good_output(hg),
      .o_fault_report_n_out(fo), .o_fault_report_n_oe(oe), .o_low_power(lp),
      .o_undervoltage_lockout(uv), .o_thermal_shutdown(otp), .o_channel_fault(chf),
      .o_fault_line_low(fll));
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic test_done();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic t_undervoltage_lockout();
      chk("lockout", 16'h1, 16'(uv));
      chk("lockout irq", 16'h1, 16'(irq));
      sup57 = 1;
      tick(4);
      chk("below 6v", 16'h0, 16'(sink));
      sup6 = 1;
      tick(4);
      chk("sinks on", 16'h3, 16'(sink));
      sup6 = 0;
      tick(4);
      chk("hysteresis", 16'h3, 16'(sink));
      sup57 = 0;
      tick(4);
      chk("lock sinks", 16'h0, 16'(sink));
      chk("lock line", 16'h1, 16'(fll));
      sup6 = 1;
      sup57 = 1;
      tick(4);
      ext_oe = 1;
      tick(3);
      chk("shared line", 16'h1, 16'(fll));
      ext_oe = 0;
      tick(3);
      chk("line free", 16'h0, 16'(fll));
      $display("undervoltage_lockout test done");
   endtask
   // Frozen core must ignore a supply drop
   task automatic t_frz();
      en = 0;
      sup57 = 0;
      tick(4);
      chk("frozen lockout", 16'h0, 16'(uv));
      chk("frozen sinks", 16'h3, 16'(sink));
      sup57 = 1;
      en = 1;
      tick(4);
      chk("thawed sinks", 16'h3, 16'(sink));
      $display("enable test done");
   endtask
   task automatic t_head();
      tick(4);
      chk("headroom good", 16'h1, 16'(hg));
      lowh = 2'h2;
      tick(4);
      chk("headroom low", 16'h0, 16'(hg));
      lvl = 2'h1;
      tick(4);
      chk("dim low ignored", 16'h1, 16'(hg));
      lowh = 2'h0;
      lvl = 2'h3;
      $display("headroom test done");
   endtask
   task automatic t_pwm();
      logic [15:0] cnt;
      cnt = 16'h0;
      lvl = 2'h2;
      pwm = 2'h1;
      tick(20);
      repeat (2000)
      begin
         cnt = cnt + {15'h0, sink[0]};
         chk("static high", 16'h1, 16'(sink[1]));
         tick(1);
      end
      chk("pulse width", 16'h00C8, cnt);
      pwm = 2'h0;
      lvl = 2'h3;
      $display("pwm test done");
   endtask
   // Open held on one channel, or a short that clears during the hold
   task automatic t_flt(input logic [1:0] m, input bit keep);
      if (keep)
         opn = m;
      else
         sht = m;
      tick(3);
      sht = 2'h0;
      tick(3);
      chk("hold line", 16'h1, 16'(fll));
      chk("hold chan", 16'(m), 16'(chf));
      chk("others run", {14'h0, ~m}, 16'(sink));
      tick(HLD - 12);
      chk("still held", 16'h1, 16'(oe));
      tick(16);
      chk("pulse over", 16'h0, 16'(oe));
      chk("retest chan", keep ? 16'(m) : 16'h0, 16'(chf));
      chk("retest sinks", keep ? {14'h0, ~m} : 16'h3, 16'(sink));
      opn = 2'h0;
      tick(4);
      chk("recovered", 16'h3, 16'(sink));
      $display("fault test done");
   endtask
   task automatic t_lp();
      lvl = 2'h0;
      tick(SLP - 4);
      chk("awake", 16'h0, 16'(lp));
      tick(12);
      chk("low power", 16'h1, 16'(lp));
      lvl = 2'h1;
      tick(2);
      chk("woken", 16'h0, 16'(lp));
      tick(4);
      chk("resumed", 16'h1, 16'(sink));
      lvl = 2'h3;
      $display("low power test done");
   endtask
   task automatic t_otp();
      // Ramp must be full first, so the restart below is visible
      tick(530);
      chk("ramp before", 16'h00FF, 16'(slev));
      t160 = 1;
      t130 = 0;
      tick(4);
      chk("shutdown", 16'h1, 16'(otp));
      chk("otp sinks", 16'h0, 16'(sink));
      chk("otp line", 16'h1, 16'(fll));
      t160 = 0;
      t130 = 1;
      tick(4);
      chk("ramp start", 16'h1, 16'(slev < 8'h10));
      tick(530);
      chk("ramp full", 16'h00FF, 16'(slev));
      chk("sinks back", 16'h3, 16'(sink));
      $display("thermal test done");
   endtask
   initial
   begin
      tick(2);
      rst_n = 1;
      tick(3);
      t_undervoltage_lockout();
      t_frz();
      t_head();
      t_pwm();
      t_flt(2'h1, 1'b1);
      t_flt(2'h2, 1'b0);
      t_lp();
      t_otp();
      test_done();
   end
   // Run needs about 3400 cycles
   initial
   begin
      #50000;
      n_mismatch++;
      test_done();
   end
endmodule // ldf_controller_tb_top
bind ldf_controller ldf_controller_monitor #(.SLEEP_CYC(SLEEP_CYC)) mon_u (.i_clock(i_clock),
   .i_rst_n(i_rst_n), .i_dimming_input(i_dimming_input), .i_led_open(i_led_open),
   .i_led_short(i_led_short), .o_channel_sink_on(o_channel_sink_on), .o_sink_level(o_sink_level),
   .o_fault_report_n_out(o_fault_report_n_out), .o_fault_report_n_oe(o_fault_report_n_oe),
   .o_low_power(o_low_power), .o_undervoltage_lockout(o_undervoltage_lockout),
   .o_thermal_shutdown(o_thermal_shutdown), .o_channel_fault(o_channel_fault));
`default_nettype wire
